// file: rtl/dsa_pkg.sv
/*
  constants, field positions and carrier types of the dsp serial port block.
  assumes a 16-bit register port with a 4-bit word index.
*/
package dsa_pkg;
  localparam int DATA_W = 16;
  localparam int RADDR_W = 4;
  localparam int MEM_AW = 11;
  localparam int DIV_W = 8;
  localparam int MUX_CNT_W = 7;
  ////////////////////////////////////////////////////////////////////////////
  // register index map
  localparam logic [3:0] ADDR_TX_DATA = 4'h0;
  localparam logic [3:0] ADDR_RX_DATA = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_CLK_DIV = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_ABU_TX_START = 4'h6;
  localparam logic [3:0] ADDR_ABU_TX_LEN = 4'h7;
  localparam logic [3:0] ADDR_ABU_RX_START = 4'h8;
  localparam logic [3:0] ADDR_ABU_RX_LEN = 4'h9;
  localparam logic [3:0] ADDR_MUX_TX_DATA = 4'hA;
  localparam logic [3:0] ADDR_MUX_RX_DATA = 4'hB;
  localparam logic [3:0] ADDR_MUX_CFG = 4'hC;
  localparam logic [3:0] ADDR_MUX_DEST = 4'hD;
  localparam logic [3:0] ADDR_ABU_TX_PTR = 4'hE;
  localparam logic [3:0] ADDR_ABU_RX_PTR = 4'hF;
  ////////////////////////////////////////////////////////////////////////////
  // control fields
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_LEN_LO = 2;
  localparam int CTRL_CONT = 4;
  localparam int CTRL_CLK_POL = 5;
  localparam int CTRL_FS_POL = 6;
  localparam int CTRL_ABU_EN_LO = 7;
  localparam int CTRL_ABU_ADIS_LO = 9;
  localparam int MCFG_OWN_LO = 0;
  localparam int MCFG_EN = 3;
  localparam int MCFG_MASK_LO = 8;
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [DIV_W-1:0] CLK_DIV_RST = 8'h03;
  // packet length codes and bit counts
  localparam logic [1:0] LEN_8 = 2'h0;
  localparam logic [1:0] LEN_10 = 2'h1;
  localparam logic [1:0] LEN_12 = 2'h2;
  localparam logic [4:0] BITS_8 = 5'h08;
  localparam logic [4:0] BITS_10 = 5'h0A;
  localparam logic [4:0] BITS_12 = 5'h0C;
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [3:0] MUX_LAST_BIT = 4'hF;
  localparam logic [3:0] MUX_ADDR_BITS = 4'h8;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic tx;
    logic rx;
    logic misalign;
    logic mux_tx;
    logic mux_rx;
  } dsa_irq_t;
  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } dsa_mem_req_t;
endpackage : dsa_pkg

// file: rtl/dsa_serial_top.sv
/*
  buffered serial port with auto-buffer unit and an eight-channel
  time-multiplexed port, behind a plain register port.
  assumes: link pins are asynchronous to ref_clk_i and much slower than it;
  the buffer memory answers a read in the cycle after the request.
*/
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ns
module dsa_serial_top
  import dsa_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [RADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output dsa_mem_req_t abu_mem_o,
  input wire logic [DATA_W-1:0] abu_mem_rdata_i,
  output logic tx_clk_o,
  output logic tx_fs_o,
  output logic tx_dat_o,
  input wire logic rx_clk_i,
  input wire logic rx_fs_i,
  input wire logic rx_dat_i,
  input wire logic mux_clk_i,
  input wire logic mux_fs_i,
  input wire logic mux_data_line_i,
  output logic mux_data_line_o,
  output logic mux_data_line_oe_o,
  input wire logic mux_addr_line_i,
  output logic mux_addr_line_o,
  output logic mux_addr_line_oe_o,
  output dsa_irq_t irq_o
);
  if (SYNC_STAGES != 2) begin : g_bad_sync
    $error("only two synchroniser stages are supported");
  end
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SHIFT = 2'b10} dsa_sh_state_t;
  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire wr_tx = reg_we_i & (reg_addr_i == ADDR_TX_DATA);
  wire rd_rx = reg_re_i & (reg_addr_i == ADDR_RX_DATA);
  wire wr_ctrl = reg_we_i & (reg_addr_i == ADDR_CTRL);
  wire wr_div = reg_we_i & (reg_addr_i == ADDR_CLK_DIV);
  wire wr_mask = reg_we_i & (reg_addr_i == ADDR_IRQ_MASK);
  wire wr_mtx = reg_we_i & (reg_addr_i == ADDR_MUX_TX_DATA);
  wire rd_mrx = reg_re_i & (reg_addr_i == ADDR_MUX_RX_DATA);
  wire wr_mcfg = reg_we_i & (reg_addr_i == ADDR_MUX_CFG);
  wire wr_mdst = reg_we_i & (reg_addr_i == ADDR_MUX_DEST);
  logic [DATA_W-1:0] ctrl_reg, mcfg_reg, tx_hold_reg, rx_data_reg, mux_tx_reg, mux_rx_reg;
  logic [DIV_W-1:0] div_reg;
  logic [7:0] mdst_reg;
  logic [4:0] mask_reg;
  wire tx_en = ctrl_reg[CTRL_TX_EN];
  wire rx_en = ctrl_reg[CTRL_RX_EN];
  wire cont = ctrl_reg[CTRL_CONT];
  wire clk_pol = ctrl_reg[CTRL_CLK_POL];
  wire fs_pol = ctrl_reg[CTRL_FS_POL];
  wire [1:0] len_code = ctrl_reg[CTRL_LEN_LO +: 2];
  wire [4:0] len_bits = (len_code == LEN_8) ? BITS_8 : (len_code == LEN_10) ? BITS_10 :
                        (len_code == LEN_12) ? BITS_12 : BITS_16;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= CTRL_RST;
      div_reg <= CLK_DIV_RST;
      mask_reg <= '0;
      mcfg_reg <= '0;
      mdst_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata_i;
      if (wr_div) div_reg <= reg_wdata_i[DIV_W-1:0];
      if (wr_mask) mask_reg <= reg_wdata_i[4:0];
      if (wr_mcfg) mcfg_reg <= reg_wdata_i;
      if (wr_mdst) mdst_reg <= reg_wdata_i[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  logic [6:0] sy1_reg, sy2_reg, syp_reg;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
      syp_reg <= '0;
    end else begin
      sy1_reg <= {rx_clk_i, rx_fs_i, rx_dat_i, mux_clk_i, mux_fs_i, mux_data_line_i,
                  mux_addr_line_i};
      sy2_reg <= sy1_reg;
      syp_reg <= sy2_reg;
    end
  end
  // edges come from comparing samples, so any slow rate works
  wire rx_samp = (sy2_reg[6] ^ clk_pol) & ~(syp_reg[6] ^ clk_pol);
  wire rx_fs_act = sy2_reg[5] ^ fs_pol;
  wire rx_bit = sy2_reg[4];
  wire mux_rise = sy2_reg[3] & ~syp_reg[3];
  wire mux_fall = ~sy2_reg[3] & syp_reg[3];
  ////////////////////////////////////////////////////////////////////////////
  // auto-buffer address generators, index 0 transmit, 1 receive
  wire [1:0] abu_en, abu_adv, abu_wrap, abu_half;
  wire [MEM_AW-1:0] abu_addr [2];
  wire [MEM_AW-1:0] abu_idx [2];
  for (genvar ch = 0; ch < 2; ch++) begin : g_abu
    localparam logic [3:0] A_START = (ch == 0) ? ADDR_ABU_TX_START : ADDR_ABU_RX_START;
    localparam logic [3:0] A_LEN = (ch == 0) ? ADDR_ABU_TX_LEN : ADDR_ABU_RX_LEN;
    logic [MEM_AW-1:0] start_reg, len_reg, idx_reg;
    logic en_reg, adis_reg;
    wire wr_start = reg_we_i & (reg_addr_i == A_START);
    wire wr_len = reg_we_i & (reg_addr_i == A_LEN);
    wire last = (idx_reg == MEM_AW'(len_reg - 1'b1));
    wire [MEM_AW-1:0] idx_inc = MEM_AW'(idx_reg + 1'b1);
    assign abu_wrap[ch] = abu_adv[ch] & last;
    assign abu_half[ch] = abu_adv[ch] & (idx_inc == (len_reg >> 1));
    assign abu_en[ch] = en_reg;
    assign abu_idx[ch] = idx_reg;
    assign abu_addr[ch] = MEM_AW'(start_reg + idx_reg);
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        start_reg <= '0;
        len_reg <= '0;
        idx_reg <= '0;
        en_reg <= 1'b0;
        adis_reg <= 1'b0;
      end else begin
        if (wr_start) start_reg <= reg_wdata_i[MEM_AW-1:0];
        if (wr_len) len_reg <= reg_wdata_i[MEM_AW-1:0];
        if (wr_start | wr_len) idx_reg <= '0;
        else if (abu_adv[ch]) idx_reg <= last ? '0 : idx_inc;
        if (wr_ctrl) begin
          en_reg <= reg_wdata_i[CTRL_ABU_EN_LO + ch];
          adis_reg <= reg_wdata_i[CTRL_ABU_ADIS_LO + ch];
        end else if (abu_wrap[ch] & adis_reg) begin
          en_reg <= 1'b0;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // dedicated memory port: receive writes beat transmit fetches
  logic rx_pend_reg, fetch1_reg, fetch2_reg, tx_full_reg;
  logic [DATA_W-1:0] rx_pend_data_reg;
  wire rx_wr_go = rx_pend_reg;
  wire tx_fetch_go = abu_en[0] & tx_en & ~tx_full_reg & ~fetch1_reg & ~fetch2_reg & ~rx_wr_go;
  assign abu_adv = {rx_wr_go, tx_fetch_go};
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      abu_mem_o <= '0;
      fetch1_reg <= 1'b0;
      fetch2_reg <= 1'b0;
    end else begin
      abu_mem_o.we <= rx_wr_go;
      abu_mem_o.re <= tx_fetch_go;
      abu_mem_o.addr <= rx_wr_go ? abu_addr[1] : abu_addr[0];
      abu_mem_o.wdata <= rx_pend_data_reg;
      fetch1_reg <= tx_fetch_go;
      fetch2_reg <= fetch1_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // transmit: clock divider and shifter
  logic [DIV_W-1:0] div_cnt_reg;
  logic tclk_reg, tfs_reg, tx_started_reg;
  logic [DATA_W-1:0] tsh_reg;
  logic [4:0] tbits_reg;
  dsa_sh_state_t tst_reg;
  wire div_tick = tx_en & (div_cnt_reg == div_reg);
  wire tx_drive = div_tick & tclk_reg;
  wire tx_last = (tbits_reg == 5'h01);
  wire tx_need = (tst_reg == ST_IDLE) | tx_last;
  wire tx_load = tx_drive & tx_need & tx_full_reg;
  wire tx_with_fs = tx_load & (~cont | ~tx_started_reg | (tst_reg == ST_IDLE));
  wire [DATA_W-1:0] tx_align = tx_hold_reg << (5'(BITS_16) - len_bits);
  wire tx_cpu_set = wr_tx & ~abu_en[0];
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt_reg <= '0;
      tclk_reg <= 1'b0;
    end else begin
      div_cnt_reg <= (~tx_en | div_tick) ? '0 : DIV_W'(div_cnt_reg + 1'b1);
      if (div_tick) tclk_reg <= ~tclk_reg;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_hold_reg <= '0;
      tx_full_reg <= 1'b0;
    end else begin
      if (tx_cpu_set) tx_hold_reg <= reg_wdata_i;
      else if (fetch2_reg) tx_hold_reg <= abu_mem_rdata_i;
      if (tx_cpu_set | fetch2_reg) tx_full_reg <= 1'b1;
      else if (tx_load) tx_full_reg <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tst_reg <= ST_IDLE;
      tsh_reg <= '0;
      tbits_reg <= '0;
      tfs_reg <= 1'b0;
      tx_started_reg <= 1'b0;
    end else if (~tx_en) begin
      tst_reg <= ST_IDLE;
      tfs_reg <= 1'b0;
      tx_started_reg <= 1'b0;
    end else if (tx_drive) begin
      tfs_reg <= tx_with_fs;
      if (tx_load) begin
        tst_reg <= ST_SHIFT;
        tsh_reg <= tx_align;
        tbits_reg <= len_bits;
        tx_started_reg <= 1'b1;
      end else if (tx_need) begin
        tst_reg <= ST_IDLE; // underrun ends a continuous run
        tx_started_reg <= 1'b0;
      end else begin
        tsh_reg <= tsh_reg << 1;
        tbits_reg <= 5'(tbits_reg - 1'b1);
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_clk_o <= 1'b0;
      tx_fs_o <= 1'b0;
      tx_dat_o <= 1'b0;
    end else begin
      tx_clk_o <= tclk_reg ^ clk_pol;
      tx_fs_o <= tfs_reg ^ fs_pol;
      tx_dat_o <= (tst_reg == ST_SHIFT) & tsh_reg[DATA_W-1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // receive shifter
  logic [DATA_W-1:0] rsh_reg;
  logic [4:0] rbits_reg;
  logic rx_full_reg, rx_ovr_reg;
  dsa_sh_state_t rst_st_reg;
  wire rx_in_word = (rst_st_reg == ST_SHIFT);
  wire rx_r_last = (rbits_reg == 5'h01);
  wire rx_start = rx_samp & rx_en & rx_fs_act & (~rx_in_word | ~cont);
  wire rx_cont_next = rx_samp & rx_in_word & rx_r_last & cont;
  wire rx_done = rx_samp & rx_in_word & rx_r_last & ~rx_start;
  wire [DATA_W-1:0] rx_word = {rsh_reg[DATA_W-2:0], rx_bit};
  wire rx_to_cpu = rx_done & ~abu_en[1];
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_st_reg <= ST_IDLE;
      rsh_reg <= '0;
      rbits_reg <= '0;
    end else if (~rx_en) begin
      rst_st_reg <= ST_IDLE;
    end else if (rx_start | rx_cont_next) begin
      rst_st_reg <= ST_SHIFT;
      rsh_reg <= rx_start ? {{(DATA_W-1){1'b0}}, rx_bit} : '0;
      rbits_reg <= rx_start ? 5'(len_bits - 1'b1) : len_bits;
    end else if (rx_samp & rx_in_word) begin
      rsh_reg <= rx_word;
      rbits_reg <= 5'(rbits_reg - 1'b1);
      if (rx_r_last) rst_st_reg <= ST_IDLE;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_data_reg <= '0;
      rx_full_reg <= 1'b0;
      rx_ovr_reg <= 1'b0;
      rx_pend_reg <= 1'b0;
      rx_pend_data_reg <= '0;
    end else begin
      if (rx_to_cpu) rx_data_reg <= rx_word;
      if (rx_to_cpu) rx_full_reg <= 1'b1;
      else if (rd_rx) rx_full_reg <= 1'b0;
      if (rx_to_cpu & rx_full_reg) rx_ovr_reg <= 1'b1;
      else if (rd_rx) rx_ovr_reg <= 1'b0;
      if (rx_done & abu_en[1]) begin
        rx_pend_reg <= 1'b1;
        rx_pend_data_reg <= rx_word;
      end else if (rx_wr_go) begin
        rx_pend_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // multiplexed port; the 7-bit position wraps every 128 clocks
  logic [MUX_CNT_W-1:0] mcnt_reg;
  logic [DATA_W-1:0] msh_tx_reg, msh_rx_reg;
  logic [7:0] mash_reg;
  logic mux_full_reg, mux_act_reg, mux_rfull_reg;
  logic [2:0] mux_rch_reg;
  wire mux_en = mcfg_reg[MCFG_EN];
  wire [2:0] own_ch = mcfg_reg[MCFG_OWN_LO +: 3];
  wire [7:0] rx_ch_mask = mcfg_reg[MCFG_MASK_LO +: 8];
  wire [MUX_CNT_W-1:0] mpos = sy2_reg[2] ? '0 : mcnt_reg;
  wire own_slot = (mcnt_reg[6:4] == own_ch);
  wire slot_first = (mcnt_reg[3:0] == 4'h0);
  wire mux_load = mux_fall & mux_en & own_slot & slot_first & mux_full_reg;
  wire mux_keep = mux_fall & own_slot & ~slot_first & mux_act_reg;
  wire [DATA_W-1:0] mrx_word = {msh_rx_reg[DATA_W-2:0], sy2_reg[1]};
  wire mux_got = mux_rise & mux_en & (mpos[3:0] == MUX_LAST_BIT) & rx_ch_mask[mpos[6:4]];
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mcnt_reg <= '0;
      msh_rx_reg <= '0;
      mux_rx_reg <= '0;
      mux_rfull_reg <= 1'b0;
      mux_rch_reg <= '0;
    end else begin
      if (mux_rise) begin
        mcnt_reg <= MUX_CNT_W'(mpos + 1'b1);
        msh_rx_reg <= mrx_word;
      end
      if (mux_got) begin
        mux_rx_reg <= mrx_word;
        mux_rch_reg <= mpos[6:4];
      end
      if (mux_got) mux_rfull_reg <= 1'b1;
      else if (rd_mrx) mux_rfull_reg <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mux_tx_reg <= '0;
      mux_full_reg <= 1'b0;
      msh_tx_reg <= '0;
      mash_reg <= '0;
      mux_act_reg <= 1'b0;
      mux_data_line_o <= 1'b0;
      mux_data_line_oe_o <= 1'b0;
      mux_addr_line_o <= 1'b0;
      mux_addr_line_oe_o <= 1'b0;
    end else begin
      if (wr_mtx) mux_tx_reg <= reg_wdata_i;
      if (wr_mtx) mux_full_reg <= 1'b1;
      else if (mux_load) mux_full_reg <= 1'b0;
      if (mux_load) begin
        msh_tx_reg <= {mux_tx_reg[DATA_W-2:0], 1'b0};
        mash_reg <= {mdst_reg[6:0], 1'b0};
        mux_data_line_o <= mux_tx_reg[DATA_W-1];
        mux_addr_line_o <= mdst_reg[7];
      end else if (mux_keep) begin
        msh_tx_reg <= msh_tx_reg << 1;
        mash_reg <= mash_reg << 1;
        mux_data_line_o <= msh_tx_reg[DATA_W-1];
        mux_addr_line_o <= mash_reg[7];
      end
      if (mux_fall) begin
        mux_act_reg <= mux_load | mux_keep;
        mux_data_line_oe_o <= mux_load | mux_keep;
        mux_addr_line_oe_o <= (mux_load | mux_keep) & (mcnt_reg[3:0] < MUX_ADDR_BITS);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // interrupts: word events without auto-buffering, buffer events with it
  wire ev_tx = abu_en[0] ? (abu_wrap[0] | abu_half[0]) : tx_load;
  wire ev_rx = abu_en[1] ? (abu_wrap[1] | abu_half[1]) : rx_to_cpu;
  wire ev_mis = cont & ((tx_drive & tx_with_fs & abu_en[0] & (abu_idx[0] != '0)) |
                        (rx_start & abu_en[1] & (abu_idx[1] != '0)));
  wire ev_mtx = mux_load;
  wire ev_mrx = mux_got;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) irq_o <= '0;
    else irq_o <= {ev_tx, ev_rx, ev_mis, ev_mtx, ev_mrx} & mask_reg;
  end
  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; status shows live state
  wire [DATA_W-1:0] status = {8'h00, mux_rch_reg, mux_rfull_reg, mux_full_reg, rx_ovr_reg,
                              rx_full_reg, tx_full_reg};
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    unique case (reg_addr_i)
      ADDR_TX_DATA: rd_mux = tx_hold_reg;
      ADDR_RX_DATA: rd_mux = rx_data_reg;
      ADDR_CTRL: rd_mux = {ctrl_reg[DATA_W-1:CTRL_ABU_ADIS_LO], abu_en,
                          ctrl_reg[CTRL_ABU_EN_LO-1:0]};
      ADDR_CLK_DIV: rd_mux = {8'h00, div_reg};
      ADDR_STATUS: rd_mux = status;
      ADDR_IRQ_MASK: rd_mux = {11'h000, mask_reg};
      ADDR_ABU_TX_START, ADDR_ABU_TX_LEN, ADDR_ABU_RX_START, ADDR_ABU_RX_LEN: rd_mux = '0;
      ADDR_MUX_TX_DATA: rd_mux = mux_tx_reg;
      ADDR_MUX_RX_DATA: rd_mux = mux_rx_reg;
      ADDR_MUX_CFG: rd_mux = mcfg_reg;
      ADDR_MUX_DEST: rd_mux = {8'h00, mdst_reg};
      ADDR_ABU_TX_PTR: rd_mux = {5'h00, abu_addr[0]};
      ADDR_ABU_RX_PTR: rd_mux = {5'h00, abu_addr[1]};
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) reg_rdata_o <= '0;
    else reg_rdata_o <= reg_re_i ? rd_mux : '0;
  end
endmodule : dsa_serial_top

// file: dv/dsa_serial_chk.sv
/* port checker for dsa_serial_top.
   assumes clk_div stays at its reset value 3 and both polarity bits stay 0. */
`timescale 1ns/1ns
module dsa_serial_chk
  import dsa_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic reg_re_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire dsa_mem_req_t abu_mem_o,
  input wire logic tx_clk_o,
  input wire logic tx_fs_o,
  input wire logic tx_dat_o,
  input wire logic mux_data_line_oe_o,
  input wire logic mux_addr_line_oe_o,
  input wire dsa_irq_t irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside its slot");
  a_rx_irq_pulse: assert property (irq_o.rx |=> !irq_o.rx)
    else $error("receive irq longer than one cycle");
  a_mem_excl: assert property (!(abu_mem_o.we && abu_mem_o.re))
    else $error("memory read and write together");
  a_mem_re_pulse: assert property (abu_mem_o.re |=> !abu_mem_o.re)
    else $error("memory read strobe too long");
  a_fs_len: assert property ($rose(tx_fs_o) |-> tx_fs_o [*8] ##1 !tx_fs_o)
    else $error("frame sync not one bit time");
  a_clk_half: assert property ($changed(tx_clk_o) |=> $stable(tx_clk_o) [*3])
    else $error("bit clock half period wrong");
  a_dat_fall: assert property ($changed(tx_dat_o) |-> !tx_clk_o)
    else $error("data changed outside falling phase");
  a_addr_in_slot: assert property (mux_addr_line_oe_o |-> mux_data_line_oe_o)
    else $error("address driven outside own slot");
  a_misalign_pulse: assert property (irq_o.misalign |=> !irq_o.misalign)
    else $error("misalign irq longer than one cycle");
  c_tx_word: cover property (irq_o.tx);
  c_abu_write: cover property (abu_mem_o.we);
  c_mux_drive: cover property ($rose(mux_data_line_oe_o));
endmodule : dsa_serial_chk
bind dsa_serial_top dsa_serial_chk dsa_serial_chk_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .abu_mem_o(abu_mem_o), .tx_clk_o(tx_clk_o),
  .tx_fs_o(tx_fs_o), .tx_dat_o(tx_dat_o), .mux_data_line_oe_o(mux_data_line_oe_o),
  .mux_addr_line_oe_o(mux_addr_line_oe_o), .irq_o(irq_o));

// file: dv/dsa_link_model.sv
/* far side: buffer memory and a free-running multiplexed link.
   assumes undriven link lines float, shown as a toggling pattern. */
`timescale 1ns/1ns
module dsa_link_model
  import dsa_pkg::*;
(
  input wire logic clk_i,
  input wire dsa_mem_req_t mem_req_i,
  output logic [DATA_W-1:0] mem_rdata_o,
  input wire logic [1:0] mux_o_i,
  input wire logic [1:0] mux_oe_i,
  output logic [1:0] mux_line_o,
  output logic mux_clk_o,
  output logic mux_fs_o
);
  logic [DATA_W-1:0] mem [2048];
  logic pat = 1'b0;
  int pos = 0;
  ////////////////////////////////////////
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 16'hA000 ^ 16'(i);
    mux_clk_o = 1'b0;
    mem_rdata_o = 16'h0000;
  end
  always #80 mux_clk_o = ~mux_clk_o;
  always @(negedge mux_clk_o) pos <= (pos + 1) % 128;
  assign mux_fs_o = (pos == 0);
  assign mux_line_o = (mux_oe_i & mux_o_i) | (~mux_oe_i & {pat, ~pat});
  always @(posedge clk_i) begin
    pat <= ~pat;
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_req_i.re) mem_rdata_o <= mem[mem_req_i.addr];
    if (mem_req_i.we) mem[mem_req_i.addr] <= mem_req_i.wdata;
  end
endmodule : dsa_link_model

// file: dv/dsa_serial_top_tb_top.sv
/* directed bench for dsa_serial_top over the register port.
   assumes transmit pins loop back to receive pins. */
`timescale 1ns/1ns
module dsa_serial_top_tb_top
  import dsa_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [15:0] reg_rdata_o, mem_rd;
  dsa_mem_req_t abu_mem_o;
  dsa_irq_t irq_o;
  logic tx_clk_o, tx_fs_o, tx_dat_o, m_clk, m_fs;
  logic [1:0] m_o, m_oe, m_in;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int cnt [5] = '{default: 0};
  int f = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  dsa_serial_top dsa_serial_top_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .abu_mem_o(abu_mem_o), .abu_mem_rdata_i(mem_rd), .tx_clk_o(tx_clk_o), .tx_fs_o(tx_fs_o),
    .tx_dat_o(tx_dat_o), .rx_clk_i(tx_clk_o), .rx_fs_i(tx_fs_o), .rx_dat_i(tx_dat_o),
    .mux_clk_i(m_clk), .mux_fs_i(m_fs), .mux_data_line_i(m_in[1]), .mux_data_line_o(m_o[1]),
    .mux_data_line_oe_o(m_oe[1]), .mux_addr_line_i(m_in[0]), .mux_addr_line_o(m_o[0]),
    .mux_addr_line_oe_o(m_oe[0]), .irq_o(irq_o));
  dsa_link_model dsa_link_model_i (.clk_i(ref_clk_i), .mem_req_i(abu_mem_o), .mem_rdata_o(mem_rd),
    .mux_o_i(m_o), .mux_oe_i(m_oe), .mux_line_o(m_in), .mux_clk_o(m_clk), .mux_fs_o(m_fs));
  ////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    cnt[0] <= cnt[0] + int'(irq_o.rx);
    cnt[1] <= cnt[1] + int'(abu_mem_o.we);
    cnt[2] <= cnt[2] + int'(irq_o.mux_rx);
    cnt[3] <= cnt[3] + int'(irq_o.mux_tx);
    cnt[4] <= cnt[4] + int'(tx_fs_o);
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_re_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask : rd
  // bounded wait for an event counter
  task automatic wait_cnt(input int k, input int n);
    int t = 0;
    while (cnt[k] < n && t < 4000) begin
      @(posedge ref_clk_i);
      t++;
    end
    chk(16'(cnt[k] >= n), 16'h0001);
  endtask : wait_cnt
  task automatic conclude();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(ADDR_CLK_DIV, 16'h0003);
    rd(ADDR_CTRL, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h001F);
    rd(ADDR_IRQ_MASK, 16'h001F);
    for (int l = 0; l < 4; l++) begin
      wr(ADDR_CTRL, 16'(l << 2) | 16'h0003);
      wr(ADDR_TX_DATA, 16'hB5C3);
      wait_cnt(0, l + 1);
      rd(ADDR_RX_DATA, 16'hB5C3 & 16'((32'h1 << ((l == 3) ? 16 : 8 + 2 * l)) - 1));
    end
    wr(ADDR_IRQ_MASK, 16'h0000);
    wr(ADDR_TX_DATA, 16'h00A5);
    repeat (400) @(posedge ref_clk_i);
    chk(16'(cnt[0]), 16'h0004);
    rd(ADDR_STATUS, 16'h0002);
    rd(ADDR_RX_DATA, 16'h00A5);
    wr(ADDR_IRQ_MASK, 16'h001F);
    // continuous: one sync of one bit time, second word follows with no gap
    wr(ADDR_CTRL, 16'h001F);
    f = cnt[4];
    wr(ADDR_TX_DATA, 16'h1234);
    repeat (10) @(posedge ref_clk_i);
    wr(ADDR_TX_DATA, 16'h5678);
    wait_cnt(0, cnt[0] + 1);
    rd(ADDR_RX_DATA, 16'h1234);
    wait_cnt(0, cnt[0] + 1);
    rd(ADDR_RX_DATA, 16'h5678);
    chk(16'(cnt[4] - f), 16'h0008);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_ABU_TX_START, 16'h0010);
    wr(ADDR_ABU_TX_LEN, 16'h0002);
    wr(ADDR_ABU_RX_START, 16'h0100);
    wr(ADDR_ABU_RX_LEN, 16'h0002);
    wr(ADDR_CTRL, 16'h018F);
    wait_cnt(1, 3);
    chk(dsa_link_model_i.mem[11'h100], 16'hA010);
    chk(dsa_link_model_i.mem[11'h101], 16'hA011);
    wr(ADDR_CTRL, 16'h078F);
    wait_cnt(1, 4);
    repeat (300) @(posedge ref_clk_i);
    rd(ADDR_CTRL, 16'h060F);
    rd(ADDR_RX_DATA, 16'hA011);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_MUX_DEST, 16'h005A);
    wr(ADDR_MUX_TX_DATA, 16'hC3A5);
    wr(ADDR_MUX_CFG, 16'h040A);
    wait_cnt(3, 1);
    wait_cnt(2, cnt[2] + 1);
    rd(ADDR_STATUS, 16'h0050);
    rd(ADDR_MUX_RX_DATA, 16'hC3A5);
    conclude();
  end
endmodule : dsa_serial_top_tb_top
